// *** include/scr_pkg.sv ***
// Constants, types and bus carriers for the system control register bank
`default_nettype none
package scr_pkg;

	// ==========================================================
	// Widths
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	localparam int MASTER_W = 2;
	localparam int BYTE_W = 8;

	// ==========================================================
	// Offsets inside the peripheral space
	localparam logic [29:0] OFF_PERIPH_BASE = 30'h0000_0000;
	localparam logic [29:0] OFF_SRAM_BASE = 30'h0000_0008;
	localparam logic [29:0] OFF_SYS_CTL = 30'h0000_0010;
	localparam logic [29:0] OFF_BUS_ARB = 30'h0000_001C;
	localparam logic [29:0] OFF_PRIV = 30'h0000_0020;
	localparam logic [29:0] OFF_ACCESS_0 = 30'h0000_0024;
	localparam logic [29:0] OFF_ACCESS_1 = 30'h0000_0028;
	localparam logic [29:0] OFF_ACCESS_2 = 30'h0000_002C;
	localparam logic [29:0] OFF_GROUP = 30'h0000_0030;
	localparam int BANK_SPAN_LO = 6;

	// ==========================================================
	// Field positions and reset values
	localparam int REGION_HI = 31;
	localparam int REGION_LO = 30;
	localparam int REGION_OK_BIT = 0;
	localparam logic [1:0] REGION_START_RESET = 2'h1;
	localparam logic REGION_OK_RESET = 1'b1;
	localparam int SRAM_BA_HI = 31;
	localparam int SRAM_BA_LO = 16;
	localparam int SRAM_ALLOW_BIT = 9;
	localparam logic [15:0] SRAM_BA_RESET = 16'h0000;
	localparam int CAUSE_PIN_BIT = 7;
	localparam int CAUSE_DOG_BIT = 6;
	localparam int DOG_RESP_BIT = 6;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam int LANE_CAUSE = 3;
	localparam int LANE_DOG_CTL = 2;
	localparam int LANE_LOW_POWER = 1;
	localparam int LANE_DOG_SVC = 0;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		REGION_NONE,
		REGION_PERIPH,
		REGION_SRAM,
		REGION_CACHE,
		REGION_SDRAM,
		REGION_CHIPSEL
	} scr_region_e;

	typedef struct packed {
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [BE_W-1:0] be;
		logic [MASTER_W-1:0] master;
		logic supervisor;
	} scr_req_s;

	typedef struct packed {
		logic ack;
		logic err;
		logic [DATA_W-1:0] rdata;
	} scr_resp_s;

endpackage
`default_nettype wire

// *** hw/scr_system_control_regs.sv ***
// System control register bank: peripheral base, module SRAM window, reset cause
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// R1 - Reset loads peripheral base 0x4000_0000 with the region_ok flag set.
// R2 - Bits 31-30 select the 1-Gbyte region holding peripheral registers.
// R3 - Bit 0 region_ok: zero stops peripheral decode, one decodes at base.
// R4 - A written base moves the peripheral window from then on.
// R5 - Overlap priority: peripheral, SRAM window, cache, SDRAM, chip selects.
// R6 - Registers at fixed offsets; 0x10 lanes: cause, dog ctl, low power, service.
// R7 - Accesses admitted or refused by the access control settings.
// R8 - Masters keep accesses inside defined maps; reserved addresses may hang.
// R9 - SRAM base register at 0x008 governs non-core module SRAM accesses.
// R10 - SRAM base bits 31-16 hold a 64-Kbyte aligned base.
// R11 - Software programs the SRAM base as a multiple of the SRAM size.
// R12 - Bit 9 allows module accesses; core-side port allow also needed.
// R13 - Reset clears module_port_allow, disabling module SRAM accesses.
// R14 - Undefined SRAM base bits ignore writes and read as zero.
// R15 - SRAM base register resets to all zeros.
// R16 - Reset cause updates once reset completes, showing the latest cause.
// R17 - At most one reset cause bit is set at a time.
// R18 - Writing one clears a cause bit; writing zero leaves it.
// R19 - Bit 7 set when the external reset input caused the last reset.
// R20 - Only pin and dog cause bits reflect the source; others reset zero.
// R21 - Dog timeout with reset response asserts internal reset, sets dog cause; code only raises DOG_RESET_REQ_OUT, cause from DOG_RESET_CAUSE_IN.
// R22 - Peripheral hit when address bits 31-30 match and region_ok is set.
module scr_system_control_regs #(
	parameter int SRAM_SIZE_LOG2 = 16
) (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire scr_pkg::scr_req_s BUS_REQ_IN,
	output var scr_pkg::scr_resp_s BUS_RESP_OUT,
	input wire logic [scr_pkg::ADDR_W-1:0] LOOKUP_ADDR_IN,
	input wire logic CACHE_HIT_IN,
	input wire logic SDRAM_HIT_IN,
	input wire logic CHIPSEL_HIT_IN,
	input wire logic CORE_SIDE_PORT_ALLOW_IN,
	output var scr_pkg::scr_region_e LOOKUP_REGION_OUT,
	output logic PERIPH_HIT_OUT,
	output logic [scr_pkg::ADDR_W-1:0] PERIPH_BASE_OUT,
	output logic [scr_pkg::ADDR_W-1:0] SRAM_BASE_OUT,
	output logic MODULE_SRAM_ENABLE_OUT,
	input wire logic PIN_RESET_CAUSE_IN,
	input wire logic DOG_RESET_CAUSE_IN,
	input wire logic DOG_TIMEOUT_IN,
	output logic DOG_RESET_REQ_OUT,
	output logic [scr_pkg::BYTE_W-1:0] DOG_CONTROL_OUT,
	output logic [scr_pkg::BYTE_W-1:0] DOG_SERVICE_OUT,
	output logic DOG_SERVICE_WR_OUT,
	output logic [scr_pkg::BYTE_W-1:0] LOW_POWER_IRQ_CTL_OUT,
	output logic [scr_pkg::DATA_W-1:0] BUS_ARB_CONFIG_OUT,
	output logic [scr_pkg::BYTE_W-1:0] MASTER_PRIVILEGE_OUT,
	output logic [9*scr_pkg::BYTE_W-1:0] PERIPH_ACCESS_CTL_OUT,
	output logic [2*scr_pkg::BYTE_W-1:0] GROUP_ACCESS_CTL_OUT
);

	// ==========================================================
	// Register state
	logic [1:0] region_start_q, region_start_d;
	logic region_ok_q, region_ok_d;
	logic [15:0] sram_ba_q, sram_ba_d;
	logic module_port_allow_q, module_port_allow_d;
	logic pin_reset_flag_q, pin_reset_flag_d;
	logic dog_reset_flag_q, dog_reset_flag_d;
	logic cause_loaded_q, cause_loaded_d;
	logic [7:0] dog_control_q, dog_control_d;
	logic [7:0] low_power_q, low_power_d;
	logic [7:0] dog_service_q, dog_service_d;
	logic dog_service_wr_q, dog_service_wr_d;
	logic dog_reset_req_q, dog_reset_req_d;
	logic [31:0] bus_arb_q, bus_arb_d;
	logic [7:0] priv_q, priv_d;
	logic [7:0] periph_access_q [9];
	logic [7:0] periph_access_d [9];
	logic [7:0] group_access_q [2];
	logic [7:0] group_access_d [2];
	scr_pkg::scr_resp_s resp_q, resp_d;
	scr_pkg::scr_region_e region_q, region_d;
	logic periph_hit_q, periph_hit_d;

	// ==========================================================
	// Decode helpers
	logic bus_in_space;
	logic bus_in_bank;
	logic [29:0] bus_off;
	logic [29:0] word_off;
	logic bus_allowed;
	logic wr_en;
	logic rd_en;
	logic hit_reg;
	logic [31:0] wdat;
	logic [3:0] be;
	logic [31:0] rdat;
	logic [31:0] sys_word;

	function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [31:0] data,
		input logic [3:0] en, input int lane);
		logic [7:0] res;
		res = old;
		if (en[lane]) begin
			res = data[lane*8 +: 8];
		end
		return res;
	endfunction

	always_comb begin
		bus_off = BUS_REQ_IN.addr[29:0];
		word_off = {bus_off[29:2], 2'b00};
		// The bank answers only while the peripheral window is enabled
		bus_in_space = region_ok_q
			&& (BUS_REQ_IN.addr[scr_pkg::REGION_HI:scr_pkg::REGION_LO] == region_start_q); // R22
		bus_in_bank = bus_in_space && (bus_off[29:scr_pkg::BANK_SPAN_LO] == '0); // R6
		bus_allowed = BUS_REQ_IN.supervisor || priv_q[BUS_REQ_IN.master]; // R7
		wdat = BUS_REQ_IN.wdata;
		be = BUS_REQ_IN.be;
		sys_word = {pin_reset_flag_q, dog_reset_flag_q, 6'h00, dog_control_q,
			low_power_q, dog_service_q}; // R6
		hit_reg = 1'b1;
		rdat = scr_pkg::WORD_RESET;
		unique case (word_off)
			scr_pkg::OFF_PERIPH_BASE: begin
				rdat = {region_start_q, 29'h0000_0000, region_ok_q};
			end
			scr_pkg::OFF_SRAM_BASE: begin
				rdat = {sram_ba_q, 6'h00, module_port_allow_q, 9'h000}; // R14
			end
			scr_pkg::OFF_SYS_CTL: begin
				rdat = sys_word;
			end
			scr_pkg::OFF_BUS_ARB: begin
				rdat = bus_arb_q;
			end
			scr_pkg::OFF_PRIV: begin
				rdat = {priv_q, 24'h00_0000};
			end
			scr_pkg::OFF_ACCESS_0: begin
				rdat = {periph_access_q[0], periph_access_q[1], periph_access_q[2],
					periph_access_q[3]};
			end
			scr_pkg::OFF_ACCESS_1: begin
				rdat = {periph_access_q[4], 8'h00, periph_access_q[5], periph_access_q[6]};
			end
			scr_pkg::OFF_ACCESS_2: begin
				rdat = {periph_access_q[7], 8'h00, periph_access_q[8], 8'h00};
			end
			scr_pkg::OFF_GROUP: begin
				rdat = {group_access_q[0], group_access_q[1], 16'h0000};
			end
			default: begin
				hit_reg = 1'b0;
			end
		endcase
		wr_en = BUS_REQ_IN.valid && BUS_REQ_IN.write && bus_in_bank && hit_reg
			&& bus_allowed; // R7
		rd_en = BUS_REQ_IN.valid && !BUS_REQ_IN.write && bus_in_bank && hit_reg
			&& bus_allowed;
	end

	// ==========================================================
	// Next-state computation
	always_comb begin
		region_start_d = region_start_q;
		region_ok_d = region_ok_q;
		sram_ba_d = sram_ba_q;
		module_port_allow_d = module_port_allow_q;
		pin_reset_flag_d = pin_reset_flag_q;
		dog_reset_flag_d = dog_reset_flag_q;
		cause_loaded_d = 1'b1;
		dog_control_d = dog_control_q;
		low_power_d = low_power_q;
		dog_service_d = dog_service_q;
		dog_service_wr_d = 1'b0;
		dog_reset_req_d = dog_reset_req_q;
		bus_arb_d = bus_arb_q;
		priv_d = priv_q;
		periph_access_d = periph_access_q;
		group_access_d = group_access_q;

		// Byte enables pick the lanes; reserved bits are never stored
		if (wr_en) begin
			unique case (word_off)
				scr_pkg::OFF_PERIPH_BASE: begin
					if (be[3]) begin
						region_start_d = wdat[scr_pkg::REGION_HI:scr_pkg::REGION_LO]; // R2 R4
					end
					if (be[0]) begin
						region_ok_d = wdat[scr_pkg::REGION_OK_BIT]; // R3
					end
				end
				scr_pkg::OFF_SRAM_BASE: begin
					if (be[3]) begin
						sram_ba_d[15:8] = wdat[31:24]; // R10
					end
					if (be[2]) begin
						sram_ba_d[7:0] = wdat[23:16]; // R10
					end
					if (be[1]) begin
						module_port_allow_d = wdat[scr_pkg::SRAM_ALLOW_BIT]; // R12 R14
					end
				end
				scr_pkg::OFF_SYS_CTL: begin
					if (be[scr_pkg::LANE_CAUSE] && wdat[24 + scr_pkg::CAUSE_PIN_BIT]) begin
						pin_reset_flag_d = 1'b0; // R18
					end
					if (be[scr_pkg::LANE_CAUSE] && wdat[24 + scr_pkg::CAUSE_DOG_BIT]) begin
						dog_reset_flag_d = 1'b0; // R18
					end
					dog_control_d = lane_merge(dog_control_q, wdat, be, scr_pkg::LANE_DOG_CTL);
					low_power_d = lane_merge(low_power_q, wdat, be, scr_pkg::LANE_LOW_POWER);
					// One-cycle strobe tells the watchdog a service byte arrived
					if (be[scr_pkg::LANE_DOG_SVC]) begin
						dog_service_d = wdat[7:0];
						dog_service_wr_d = 1'b1;
					end
				end
				scr_pkg::OFF_BUS_ARB: begin
					for (int i = 0; i < 4; i++) begin
						bus_arb_d[i*8 +: 8] = lane_merge(bus_arb_q[i*8 +: 8], wdat, be, i);
					end
				end
				scr_pkg::OFF_PRIV: begin
					priv_d = lane_merge(priv_q, wdat, be, 3);
				end
				scr_pkg::OFF_ACCESS_0: begin
					periph_access_d[0] = lane_merge(periph_access_q[0], wdat, be, 3);
					periph_access_d[1] = lane_merge(periph_access_q[1], wdat, be, 2);
					periph_access_d[2] = lane_merge(periph_access_q[2], wdat, be, 1);
					periph_access_d[3] = lane_merge(periph_access_q[3], wdat, be, 0);
				end
				scr_pkg::OFF_ACCESS_1: begin
					periph_access_d[4] = lane_merge(periph_access_q[4], wdat, be, 3);
					periph_access_d[5] = lane_merge(periph_access_q[5], wdat, be, 1);
					periph_access_d[6] = lane_merge(periph_access_q[6], wdat, be, 0);
				end
				scr_pkg::OFF_ACCESS_2: begin
					periph_access_d[7] = lane_merge(periph_access_q[7], wdat, be, 3);
					periph_access_d[8] = lane_merge(periph_access_q[8], wdat, be, 1);
				end
				scr_pkg::OFF_GROUP: begin
					group_access_d[0] = lane_merge(group_access_q[0], wdat, be, 3);
					group_access_d[1] = lane_merge(group_access_q[1], wdat, be, 2);
				end
				default: begin
				end
			endcase
		end

		// First cycle after reset release: latch the cause, which beats a clear
		if (!cause_loaded_q) begin
			pin_reset_flag_d = PIN_RESET_CAUSE_IN; // R16 R19
			dog_reset_flag_d = DOG_RESET_CAUSE_IN && !PIN_RESET_CAUSE_IN; // R17 R20
		end

		// Held until the reset it requests clears it
		if (DOG_TIMEOUT_IN && dog_control_q[scr_pkg::DOG_RESP_BIT]) begin
			dog_reset_req_d = 1'b1; // R21
		end
	end

	// ==========================================================
	// Bus answer and address lookup
	always_comb begin
		resp_d.ack = 1'b0;
		resp_d.err = 1'b0;
		resp_d.rdata = scr_pkg::WORD_RESET;
		// Unmapped bank words answer with an error instead of hanging the bus
		if (BUS_REQ_IN.valid && bus_in_bank) begin
			resp_d.ack = 1'b1;
			resp_d.err = !(hit_reg && bus_allowed); // R7
			if (rd_en) begin
				resp_d.rdata = rdat;
			end
		end

		// Lookup order: peripheral space, SRAM window, cache, SDRAM, chip selects
		periph_hit_d = region_ok_q
			&& (LOOKUP_ADDR_IN[scr_pkg::REGION_HI:scr_pkg::REGION_LO] == region_start_q); // R22 R3
		if (periph_hit_d) begin
			region_d = scr_pkg::REGION_PERIPH; // R5
		end else if (module_port_allow_q && CORE_SIDE_PORT_ALLOW_IN
			&& (LOOKUP_ADDR_IN[scr_pkg::ADDR_W-1:SRAM_SIZE_LOG2]
			== SRAM_BASE_OUT[scr_pkg::ADDR_W-1:SRAM_SIZE_LOG2])) begin
			region_d = scr_pkg::REGION_SRAM; // R5 R9 R12
		end else if (CACHE_HIT_IN) begin
			region_d = scr_pkg::REGION_CACHE; // R5
		end else if (SDRAM_HIT_IN) begin
			region_d = scr_pkg::REGION_SDRAM; // R5
		end else if (CHIPSEL_HIT_IN) begin
			region_d = scr_pkg::REGION_CHIPSEL; // R5
		end else begin
			region_d = scr_pkg::REGION_NONE;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			region_start_q <= scr_pkg::REGION_START_RESET; // R1
			region_ok_q <= scr_pkg::REGION_OK_RESET; // R1
			sram_ba_q <= scr_pkg::SRAM_BA_RESET; // R15
			module_port_allow_q <= 1'b0; // R13
			pin_reset_flag_q <= 1'b0; // R20
			dog_reset_flag_q <= 1'b0; // R20
			cause_loaded_q <= 1'b0; // R16
			dog_control_q <= scr_pkg::BYTE_RESET;
			low_power_q <= scr_pkg::BYTE_RESET;
			dog_service_q <= scr_pkg::BYTE_RESET;
			dog_service_wr_q <= 1'b0;
			dog_reset_req_q <= 1'b0;
			bus_arb_q <= scr_pkg::WORD_RESET;
			priv_q <= scr_pkg::BYTE_RESET;
			for (int i = 0; i < 9; i++) begin
				periph_access_q[i] <= scr_pkg::BYTE_RESET;
			end
			for (int i = 0; i < 2; i++) begin
				group_access_q[i] <= scr_pkg::BYTE_RESET;
			end
			resp_q <= '0;
			region_q <= scr_pkg::REGION_NONE;
			periph_hit_q <= 1'b0;
		end else begin
			region_start_q <= region_start_d;
			region_ok_q <= region_ok_d;
			sram_ba_q <= sram_ba_d;
			module_port_allow_q <= module_port_allow_d;
			pin_reset_flag_q <= pin_reset_flag_d;
			dog_reset_flag_q <= dog_reset_flag_d;
			cause_loaded_q <= cause_loaded_d;
			dog_control_q <= dog_control_d;
			low_power_q <= low_power_d;
			dog_service_q <= dog_service_d;
			dog_service_wr_q <= dog_service_wr_d;
			dog_reset_req_q <= dog_reset_req_d;
			bus_arb_q <= bus_arb_d;
			priv_q <= priv_d;
			periph_access_q <= periph_access_d;
			group_access_q <= group_access_d;
			resp_q <= resp_d;
			region_q <= region_d;
			periph_hit_q <= periph_hit_d;
		end
	end

	// ==========================================================
	// Outputs, all straight from flip-flops
	always_comb begin
		BUS_RESP_OUT = resp_q;
		LOOKUP_REGION_OUT = region_q;
		PERIPH_HIT_OUT = periph_hit_q;
		PERIPH_BASE_OUT = {region_start_q, 29'h0000_0000, region_ok_q};
		SRAM_BASE_OUT = {sram_ba_q, 16'h0000}; // R10
		MODULE_SRAM_ENABLE_OUT = module_port_allow_q; // R12
		DOG_RESET_REQ_OUT = dog_reset_req_q;
		DOG_CONTROL_OUT = dog_control_q;
		DOG_SERVICE_OUT = dog_service_q;
		DOG_SERVICE_WR_OUT = dog_service_wr_q;
		LOW_POWER_IRQ_CTL_OUT = low_power_q;
		BUS_ARB_CONFIG_OUT = bus_arb_q;
		MASTER_PRIVILEGE_OUT = priv_q;
		for (int i = 0; i < 9; i++) begin
			PERIPH_ACCESS_CTL_OUT[i*8 +: 8] = periph_access_q[i];
		end
		for (int i = 0; i < 2; i++) begin
			GROUP_ACCESS_CTL_OUT[i*8 +: 8] = group_access_q[i];
		end
	end

endmodule // scr_system_control_regs
`default_nettype wire

// *** tb/scr_regs_chk_sva.sv ***
// Concurrent checks on the ports of the system control register bank
`timescale 1ns/100ps
`default_nettype none
module scr_regs_chk #(
	parameter int SRAM_SIZE_LOG2 = 16
) (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire scr_pkg::scr_req_s BUS_REQ_IN,
	input wire scr_pkg::scr_resp_s BUS_RESP_OUT,
	input wire logic [31:0] LOOKUP_ADDR_IN,
	input wire logic CORE_SIDE_PORT_ALLOW_IN,
	input wire scr_pkg::scr_region_e LOOKUP_REGION_OUT,
	input wire logic PERIPH_HIT_OUT,
	input wire logic [31:0] PERIPH_BASE_OUT,
	input wire logic [31:0] SRAM_BASE_OUT,
	input wire logic MODULE_SRAM_ENABLE_OUT,
	input wire logic DOG_TIMEOUT_IN,
	input wire logic DOG_RESET_REQ_OUT,
	input wire logic [7:0] DOG_CONTROL_OUT,
	input wire logic [7:0] MASTER_PRIVILEGE_OUT
);
	// ==========================================================
	// Bank access decode
	logic taken;
	assign taken = BUS_REQ_IN.valid && (BUS_REQ_IN.addr[31:30] == PERIPH_BASE_OUT[31:30])
		&& PERIPH_BASE_OUT[0] && (BUS_REQ_IN.addr[29:6] == 24'h00_0000);

	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (RST_IN);

	// ==========================================================
	// Properties
	a_ack_follows: assert property (taken |=> BUS_RESP_OUT.ack)
		else $error("bank access not acknowledged one cycle later");
	a_no_stray_ack: assert property (BUS_RESP_OUT.ack |-> $past(taken))
		else $error("acknowledge without an accepted access");
	a_err_clean: assert property (BUS_RESP_OUT.err |-> BUS_RESP_OUT.ack
		&& BUS_RESP_OUT.rdata == 32'h0000_0000)
		else $error("error response not clean");
	a_user_denied: assert property (taken && !BUS_REQ_IN.supervisor
		&& !MASTER_PRIVILEGE_OUT[BUS_REQ_IN.master] |=> BUS_RESP_OUT.err)
		else $error("unprivileged access not refused");
	a_hit_match: assert property (1'b1 |=> PERIPH_HIT_OUT == ($past(PERIPH_BASE_OUT[0])
		&& $past(LOOKUP_ADDR_IN[31:30]) == $past(PERIPH_BASE_OUT[31:30])))
		else $error("peripheral hit wrong");
	a_hit_wins: assert property (PERIPH_HIT_OUT |-> LOOKUP_REGION_OUT == scr_pkg::REGION_PERIPH)
		else $error("peripheral space not highest priority");
	a_sram_gate: assert property (LOOKUP_REGION_OUT == scr_pkg::REGION_SRAM
		|-> $past(MODULE_SRAM_ENABLE_OUT) && $past(CORE_SIDE_PORT_ALLOW_IN))
		else $error("sram window hit without both port allows");
	a_sram_low_zero: assert property (SRAM_BASE_OUT[15:0] == 16'h0000)
		else $error("sram base low bits not zero");
	a_cause_onehot: assert property ($past(taken && !BUS_REQ_IN.write
		&& BUS_REQ_IN.addr[5:2] == 4'h4) && BUS_RESP_OUT.ack && !BUS_RESP_OUT.err
		|-> $onehot0(BUS_RESP_OUT.rdata[31:24]))
		else $error("more than one reset cause bit set");
	a_dog_reset: assert property (DOG_TIMEOUT_IN && DOG_CONTROL_OUT[6] |=> DOG_RESET_REQ_OUT)
		else $error("dog timeout did not request reset");
	a_dog_sticky: assert property (DOG_RESET_REQ_OUT |=> DOG_RESET_REQ_OUT)
		else $error("dog reset request dropped");
endmodule // scr_regs_chk

bind scr_system_control_regs scr_regs_chk #(.SRAM_SIZE_LOG2(SRAM_SIZE_LOG2)) chk_i (
	.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .BUS_REQ_IN(BUS_REQ_IN),
	.BUS_RESP_OUT(BUS_RESP_OUT), .LOOKUP_ADDR_IN(LOOKUP_ADDR_IN),
	.CORE_SIDE_PORT_ALLOW_IN(CORE_SIDE_PORT_ALLOW_IN), .LOOKUP_REGION_OUT(LOOKUP_REGION_OUT),
	.PERIPH_HIT_OUT(PERIPH_HIT_OUT), .PERIPH_BASE_OUT(PERIPH_BASE_OUT),
	.SRAM_BASE_OUT(SRAM_BASE_OUT), .MODULE_SRAM_ENABLE_OUT(MODULE_SRAM_ENABLE_OUT),
	.DOG_TIMEOUT_IN(DOG_TIMEOUT_IN), .DOG_RESET_REQ_OUT(DOG_RESET_REQ_OUT),
	.DOG_CONTROL_OUT(DOG_CONTROL_OUT), .MASTER_PRIVILEGE_OUT(MASTER_PRIVILEGE_OUT));
`default_nettype wire

// *** tb/scr_master_model.sv ***
// Internal bus master model issuing single accesses to the register bank
`timescale 1ns/100ps
`default_nettype none
module scr_master_model (
	input wire logic clk_in,
	input wire scr_pkg::scr_resp_s resp_in,
	output var scr_pkg::scr_req_s req_out
);
	// ==========================================================
	// One access: valid for one edge, answer looked at half a cycle after that edge
	initial req_out = '0;

	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		input logic [3:0] be, input logic sup, output logic [31:0] rd, output logic er,
		output logic ak);
		scr_pkg::scr_req_s r;
		r = '{valid: 1'b1, write: wr, addr: a, wdata: wd, be: be, master: 2'h0, supervisor: sup};
		@(posedge clk_in);
		req_out <= r;
		@(posedge clk_in);
		// Released lines show the inverse, not a stale copy
		r = ~r;
		r.valid = 1'b0;
		req_out <= r;
		@(negedge clk_in);
		ak = resp_in.ack;
		er = resp_in.err;
		rd = resp_in.rdata;
	endtask
endmodule // scr_master_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking testbench for the system control register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	// ==========================================================
	// Stimulus and observed signals
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	scr_pkg::scr_req_s req;
	scr_pkg::scr_resp_s resp;
	logic [31:0] lk_addr = 32'h0000_0000;
	logic core_allow = 1'b0, cache = 1'b0, sdram = 1'b0, chipsel = 1'b0;
	logic pin_c = 1'b1, dog_c = 1'b0, dog_to = 1'b0;
	scr_pkg::scr_region_e region;
	logic hit, sen, dog_req, ak, er;
	logic [31:0] pbase, sbase, rd;
	logic [7:0] dog_ctl, lp, svc, mpriv;
	logic svc_wr;
	logic [31:0] arb;
	logic [71:0] pacc;
	logic [15:0] gacc;
	int n_fail = 0;
	int compares = 0;

	always #2 clock_in = ~clock_in;

	scr_master_model scr_master_model_i (.clk_in(clock_in), .resp_in(resp), .req_out(req));

	scr_system_control_regs scr_system_control_regs_i (
		.CLOCK_IN(clock_in), .RST_IN(rst_in), .BUS_REQ_IN(req), .BUS_RESP_OUT(resp),
		.LOOKUP_ADDR_IN(lk_addr), .CACHE_HIT_IN(cache), .SDRAM_HIT_IN(sdram),
		.CHIPSEL_HIT_IN(chipsel), .CORE_SIDE_PORT_ALLOW_IN(core_allow),
		.LOOKUP_REGION_OUT(region), .PERIPH_HIT_OUT(hit), .PERIPH_BASE_OUT(pbase),
		.SRAM_BASE_OUT(sbase), .MODULE_SRAM_ENABLE_OUT(sen), .PIN_RESET_CAUSE_IN(pin_c),
		.DOG_RESET_CAUSE_IN(dog_c), .DOG_TIMEOUT_IN(dog_to), .DOG_RESET_REQ_OUT(dog_req),
		.DOG_CONTROL_OUT(dog_ctl), .DOG_SERVICE_OUT(svc), .DOG_SERVICE_WR_OUT(svc_wr),
		.LOW_POWER_IRQ_CTL_OUT(lp), .BUS_ARB_CONFIG_OUT(arb), .MASTER_PRIVILEGE_OUT(mpriv),
		.PERIPH_ACCESS_CTL_OUT(pacc), .GROUP_ACCESS_CTL_OUT(gacc));

	// ==========================================================
	// Compare, access and lookup tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string what);
		chk({31'h0000_0000, got}, {31'h0000_0000, exp}, what);
	endtask

	task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		input logic [3:0] be, input logic sup, input logic exp_err);
		scr_master_model_i.xfer(wr, a, wd, be, sup, rd, er, ak);
		chk_bit(ak, 1'b1, "ack");
		chk_bit(er, exp_err, "err");
	endtask

	task automatic look(input logic [31:0] a, input logic [3:0] h, input scr_pkg::scr_region_e e);
		@(posedge clock_in);
		lk_addr <= a;
		{core_allow, cache, sdram, chipsel} <= h;
		@(posedge clock_in);
		@(negedge clock_in);
		chk(32'(region), 32'(e), "region");
		chk_bit(hit, e == scr_pkg::REGION_PERIPH, "hit");
	endtask

	task automatic reset_run(input logic pin, input logic dog);
		@(posedge clock_in);
		rst_in <= 1'b1;
		pin_c <= pin;
		dog_c <= dog;
		repeat (3) @(posedge clock_in);
		rst_in <= 1'b0;
		repeat (2) @(posedge clock_in);
	endtask

	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================================
	// Test sequence
	initial begin
		reset_run(1'b1, 1'b0);
		@(negedge clock_in);
		chk(pbase, 32'h4000_0001, "base out");
		acc(0, 32'h4000_0000, 32'h0000_0000, 4'hF, 1, 0);
		chk(rd, 32'h4000_0001, "base read");
		acc(0, 32'h4000_0008, 32'h0000_0000, 4'hF, 1, 0);
		chk(rd, 32'h0000_0000, "sram reset");
		acc(0, 32'h4000_0010, 32'h0000_0000, 4'hF, 1, 0);
		chk(rd, 32'h8000_0000, "pin cause");
		acc(1, 32'h4000_0010, 32'h7F00_0000, 4'h8, 1, 0);
		acc(0, 32'h4000_0010, 32'h0000_0000, 4'hF, 1, 0);
		chk(rd, 32'h8000_0000, "zero write keeps");
		acc(1, 32'h4000_0010, 32'h8000_0000, 4'h8, 1, 0);
		acc(0, 32'h4000_0010, 32'h0000_0000, 4'hF, 1, 0);
		chk(rd, 32'h0000_0000, "one write clears");
		$display("TEST reset and cause done");
		acc(1, 32'h4000_0008, 32'hFFFF_0200, 4'hF, 0, 1);
		acc(0, 32'h4000_0004, 32'h0000_0000, 4'hF, 1, 1);
		acc(0, 32'h4000_0008, 32'h0000_0000, 4'hF, 1, 0);
		chk(rd, 32'h0000_0000, "denied write");
		acc(1, 32'h4000_0008, 32'h2003_FFFF, 4'hF, 1, 0);
		acc(0, 32'h4000_0008, 32'h0000_0000, 4'hF, 1, 0);
		chk(rd, 32'h2003_0200, "sram read");
		chk(sbase, 32'h2003_0000, "sram out");
		chk_bit(sen, 1'b1, "module allow");
		$display("TEST access and sram done");
		acc(1, 32'h4000_0020, 32'h0100_0000, 4'h8, 1, 0);
		chk({24'h00_0000, mpriv}, 32'h0000_0001, "privilege out");
		acc(1, 32'h4000_0024, 32'h1122_3344, 4'hF, 0, 0);
		acc(0, 32'h4000_0024, 32'h0000_0000, 4'hF, 0, 0);
		chk(rd, 32'h1122_3344, "access read");
		chk(pacc[31:0], 32'h4433_2211, "access out");
		acc(1, 32'h4000_002C, 32'hFFFF_FFFF, 4'hF, 1, 0);
		acc(0, 32'h4000_002C, 32'h0000_0000, 4'hF, 1, 0);
		chk(rd, 32'hFF00_FF00, "reserved lanes zero");
		chk({16'h0000, pacc[71:56]}, 32'h0000_FFFF, "upper access out");
		acc(1, 32'h4000_001C, 32'hA5A5_0F0F, 4'h5, 1, 0);
		chk(arb, 32'h00A5_000F, "arb lanes");
		acc(1, 32'h4000_0010, 32'h0000_5A55, 4'h3, 1, 0);
		chk_bit(svc_wr, 1'b1, "service strobe");
		chk({16'h0000, lp, svc}, 32'h0000_5A55, "low power and service");
		acc(1, 32'h4000_0030, 32'hC33C_FFFF, 4'hF, 1, 0);
		chk({16'h0000, gacc}, 32'h0000_3CC3, "group out");
		chk_bit(svc_wr, 1'b0, "service strobe ends");
		$display("TEST control bytes done");
		look(32'h2003_1234, 4'hF, scr_pkg::REGION_SRAM);
		look(32'h2003_1234, 4'h7, scr_pkg::REGION_CACHE);
		look(32'h2003_1234, 4'h3, scr_pkg::REGION_SDRAM);
		look(32'h2003_1234, 4'h1, scr_pkg::REGION_CHIPSEL);
		look(32'h4000_0100, 4'hF, scr_pkg::REGION_PERIPH);
		look(32'h1000_0000, 4'h0, scr_pkg::REGION_NONE);
		$display("TEST lookup done");
		acc(1, 32'h4000_0010, 32'h0040_0000, 4'h4, 1, 0);
		chk({24'h00_0000, dog_ctl}, 32'h0000_0040, "dog control");
		@(posedge clock_in);
		dog_to <= 1'b1;
		@(posedge clock_in);
		dog_to <= 1'b0;
		@(negedge clock_in);
		chk_bit(dog_req, 1'b1, "dog reset request");
		$display("TEST dog done");
		acc(1, 32'h4000_0000, 32'h8000_0001, 4'hF, 1, 0);
		acc(0, 32'h8000_0000, 32'h0000_0000, 4'hF, 1, 0);
		chk(rd, 32'h8000_0001, "moved base");
		look(32'h4000_0000, 4'h0, scr_pkg::REGION_NONE);
		look(32'h8000_0010, 4'h0, scr_pkg::REGION_PERIPH);
		acc(1, 32'h8000_0000, 32'h8000_0000, 4'hF, 1, 0);
		look(32'h8000_0010, 4'h1, scr_pkg::REGION_CHIPSEL);
		$display("TEST base move done");
		reset_run(1'b0, 1'b1);
		acc(0, 32'h4000_0010, 32'h0000_0000, 4'hF, 1, 0);
		chk(rd, 32'h4000_0000, "dog cause");
		chk_bit(dog_req, 1'b0, "request cleared");
		chk_bit(sen, 1'b0, "allow cleared");
		$display("TEST second reset done");
		print_verdict();
	end

	initial begin
		#100000;
		n_fail++;
		$display("ERROR %0t run did not finish", $time);
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
